// ---- rtl/rcr_top.sv ----
// rcr_top: reset cause recorder with AHB-Lite register slave
// assumes i_nrst is the power-on reset only; other resets come as event inputs
`timescale 1ns/1ps
module rcr_top #(
   parameter int PC_W = 16
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // events from the core, one-cycle pulses on the same clock; the reset pin is an asynchronous level, sleeping and pc are levels
   input wire logic i_brownout,
   input wire logic i_wdog_timeout,
   input wire logic i_wdog_window_viol,
   input wire logic i_ext_reset_pin,
   input wire logic i_reset_instr,
   input wire logic i_stack_over,
   input wire logic i_stack_under,
   input wire logic i_wake_wdog,
   input wire logic i_wake_irq,
   input wire logic i_sleeping,
   input wire logic [PC_W-1:0] i_pc,
   // restart and interrupt outputs
   output logic o_restart,
   output logic [PC_W-1:0] o_restart_pc,
   output logic o_irq
);
   import rcr_pkg::*;

   // external pin is asynchronous; active-low level, act on assertion only
   logic pin_ev;
   rcr_sync u_pin_sync (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_async(!i_ext_reset_pin),
      .o_level(),
      .o_rise(pin_ev)
   );

   logic [7:0] pwrctl;
   logic [1:0] status;
   logic [1:0] ctrl;
   logic [RCR_NEV-1:0] irq_st;
   logic [RCR_NEV-1:0] irq_msk;

   // qualified events; stack events gated by enable
   wire ev_ovr = i_stack_over && ctrl[RCR_B_STKEN];
   wire ev_und = i_stack_under && ctrl[RCR_B_STKEN];
   wire ev_pin_wake = pin_ev && i_sleeping;
   wire [RCR_NEV-1:0] ev_vec = {i_wake_irq, i_wake_wdog, ev_und, ev_ovr, i_reset_instr,
                                pin_ev, i_wdog_window_viol, i_wdog_timeout, i_brownout};

   // ahb address phase capture
   logic dp_wr;
   logic dp_rd;
   logic [7:0] dp_addr;
   wire ap_valid = i_hsel && i_hready && i_htrans[1];
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_wr <= ap_valid && i_hwrite;
         dp_rd <= ap_valid && !i_hwrite;
         dp_addr <= i_haddr[7:0];
      end
   end
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // write strobes for pwrctl, irq status, irq mask and ctrl
   wire wr_pwr = dp_wr && (dp_addr == RCR_OFF_PWRCTL);
   wire wr_ist = dp_wr && (dp_addr == RCR_OFF_IRQ_ST);
   wire wr_msk = dp_wr && (dp_addr == RCR_OFF_IRQ_MSK);
   wire wr_ctl = dp_wr && (dp_addr == RCR_OFF_CTRL);
   wire [7:0] wd = i_hwdata[7:0];

   // firmware effect: low flags only settable, stack flags only clearable
   function automatic logic [7:0] fw_apply(input logic [7:0] cur, input logic [7:0] w);
      logic [7:0] r;
      r = cur | (w & 8'h3F);
      r[RCR_B_STKOVR] = cur[RCR_B_STKOVR] & w[RCR_B_STKOVR];
      r[RCR_B_STKUND] = cur[RCR_B_STKUND] & w[RCR_B_STKUND];
      return r;
   endfunction

   // hardware effect on flags, applied after firmware so events win
   logic [7:0] next_pwrctl;
   logic [1:0] next_status;
   always_comb begin
      next_pwrctl = wr_pwr ? fw_apply(pwrctl, wd) : pwrctl;
      next_status = status;
      if (i_brownout) begin
         next_pwrctl[RCR_B_BROWN] = 1'b0;
         next_pwrctl[RCR_B_STKOVR] = 1'b0;
         next_pwrctl[RCR_B_STKUND] = 1'b0;
         next_pwrctl[RCR_B_PIN] = 1'b1;
         next_pwrctl[RCR_B_INSTR] = 1'b1;
         next_status = RCR_STATUS_POR;
      end
      if (i_wdog_timeout) begin
         next_pwrctl[RCR_B_WDOG] = 1'b0;
         next_status[1] = 1'b0;
      end
      if (i_wdog_window_viol) begin
         next_pwrctl[RCR_B_WINV] = 1'b0;
         next_status[1] = 1'b1;
      end
      if (pin_ev) begin
         next_pwrctl[RCR_B_PIN] = 1'b0;
      end
      if (ev_pin_wake) begin
         next_status = 2'h2;
      end
      if (i_reset_instr) begin
         next_pwrctl[RCR_B_INSTR] = 1'b0;
      end
      if (ev_ovr) begin
         next_pwrctl[RCR_B_STKOVR] = 1'b1;
      end
      if (ev_und) begin
         next_pwrctl[RCR_B_STKUND] = 1'b1;
      end
      if (i_wake_wdog) begin
         next_status = 2'h0;
      end
      if (i_wake_irq) begin
         next_status = 2'h2;
      end
   end

   // flags reset only by power-on; other resets are events here
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pwrctl <= RCR_PWRCTL_POR;
         status <= RCR_STATUS_POR;
      end else begin
         pwrctl <= next_pwrctl;
         status <= next_status;
      end
   end

   // control, mask and sticky interrupt status; set wins over clear
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl <= RCR_CTRL_RST;
         irq_msk <= '0;
         irq_st <= '0;
      end else begin
         if (wr_ctl) begin
            ctrl <= wd[1:0];
         end
         if (wr_msk) begin
            irq_msk <= i_hwdata[RCR_NEV-1:0];
         end
         irq_st <= (irq_st & ~(wr_ist ? i_hwdata[RCR_NEV-1:0] : '0)) | ev_vec;
      end
   end
   assign o_irq = |(irq_st & irq_msk);

   // restart target choice
   rcr_go_e go;
   always_comb begin
      go = RCR_GO_NONE;
      if (i_brownout || i_wdog_timeout || i_wdog_window_viol || pin_ev || i_reset_instr
          || ev_ovr || ev_und) begin
         go = RCR_GO_ZERO;
      end else if (i_wake_irq && ctrl[RCR_B_GIE]) begin
         go = RCR_GO_VEC;
      end else if (i_wake_wdog || i_wake_irq) begin
         go = RCR_GO_NEXT;
      end
   end

   // restart pulse and pc; vector taken after the next instruction by the core
   logic restart_q;
   logic [PC_W-1:0] rpc_q;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         restart_q <= 1'b1;
         rpc_q <= RCR_PC_ZERO[PC_W-1:0];
      end else begin
         restart_q <= (go != RCR_GO_NONE);
         case (go)
            RCR_GO_ZERO: rpc_q <= RCR_PC_ZERO[PC_W-1:0];
            RCR_GO_NEXT: rpc_q <= PC_W'(i_pc + 1'b1);
            RCR_GO_VEC: rpc_q <= RCR_PC_VECTOR[PC_W-1:0];
            RCR_GO_NONE: rpc_q <= rpc_q;
            default: rpc_q <= rpc_q;
         endcase
      end
   end
   assign o_restart = restart_q;
   assign o_restart_pc = rpc_q;

   // read mux; unmapped offsets read zero
   logic [31:0] rd_mux;
   always_comb begin
      case (dp_addr)
         RCR_OFF_PWRCTL: rd_mux = {24'h000000, pwrctl};
         RCR_OFF_STATUS: rd_mux = {27'h0000000, status, 3'h0};
         RCR_OFF_IRQ_ST: rd_mux = {{(32-RCR_NEV){1'b0}}, irq_st};
         RCR_OFF_IRQ_MSK: rd_mux = {{(32-RCR_NEV){1'b0}}, irq_msk};
         RCR_OFF_CTRL: rd_mux = {30'h00000000, ctrl};
         RCR_OFF_PC: rd_mux = {{(32-PC_W){1'b0}}, rpc_q};
         default: rd_mux = 32'h00000000;
      endcase
   end
   assign o_hrdata = dp_rd ? rd_mux : 32'h00000000;

   // assertions
   // later events in the same cycle may set expiry again, so they are left out here
   a_wdog_clears_flag: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_wdog_timeout && !i_wdog_window_viol && !ev_pin_wake && !i_wake_irq
      |=> !pwrctl[RCR_B_WDOG] && !status[1])
      else $error("watchdog flag not cleared");
   a_winv_sets_exp: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_wdog_window_viol && !i_wake_wdog && !ev_pin_wake
      |=> !pwrctl[RCR_B_WINV] && status[1])
      else $error("window violation flags wrong");
   a_instr_flag: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_reset_instr |=> !pwrctl[RCR_B_INSTR] && o_restart && o_restart_pc == '0)
      else $error("reset instruction handling wrong");
   a_stack_gate: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_stack_over && ctrl[RCR_B_STKEN] |=> pwrctl[RCR_B_STKOVR])
      else $error("overflow flag not set");
   a_wake_next_pc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_wake_wdog && !i_wake_irq && go == RCR_GO_NEXT
      |=> status == 2'h0 && o_restart_pc == PC_W'($past(i_pc) + 1'b1))
      else $error("watchdog wake wrong");
   a_irq_wake_vec: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      go == RCR_GO_VEC |=> o_restart_pc == RCR_PC_VECTOR[PC_W-1:0] && status == 2'h2)
      else $error("interrupt wake wrong");
   a_brown_flags: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_brownout && !(pin_ev || i_reset_instr || ev_ovr || ev_und || i_wake_wdog || i_wake_irq
      || i_wdog_timeout) |=> pwrctl[7:6] == 2'h0 && pwrctl[3:2] == 2'h3 && !pwrctl[0]
      && status == RCR_STATUS_POR)
      else $error("brown-out flags wrong");
   a_pin_sleep: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      ev_pin_wake && !i_wake_wdog && !i_wake_irq && !i_brownout |=> status == 2'h2
      && !pwrctl[RCR_B_PIN])
      else $error("pin reset in sleep wrong");
   a_fw_no_clear: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      !(|ev_vec) && !wr_pwr |=> pwrctl == $past(pwrctl))
      else $error("flags changed without cause");
endmodule // rcr_top

// ---- rtl/rcr_pkg.sv ----
// rcr_pkg: constants for the reset cause recorder
// assumes a 32-bit AHB-Lite register bus, word-aligned registers
package rcr_pkg;
   // register byte offsets
   localparam logic [7:0] RCR_OFF_PWRCTL = 8'h00;
   localparam logic [7:0] RCR_OFF_STATUS = 8'h04;
   localparam logic [7:0] RCR_OFF_IRQ_ST = 8'h08;
   localparam logic [7:0] RCR_OFF_IRQ_MSK = 8'h0C;
   localparam logic [7:0] RCR_OFF_CTRL = 8'h10;
   localparam logic [7:0] RCR_OFF_PC = 8'h14;
   // power_control_flags bit positions
   localparam int RCR_B_STKOVR = 7;
   localparam int RCR_B_STKUND = 6;
   localparam int RCR_B_WINV = 5;
   localparam int RCR_B_WDOG = 4;
   localparam int RCR_B_PIN = 3;
   localparam int RCR_B_INSTR = 2;
   localparam int RCR_B_PWRON = 1;
   localparam int RCR_B_BROWN = 0;
   // core_status bit positions
   localparam int RCR_B_EXPIRY = 4;
   localparam int RCR_B_PWRDN = 3;
   // power-on values; brown-out flag left at 0 for determinism
   localparam logic [7:0] RCR_PWRCTL_POR = 8'h3C;
   localparam logic [1:0] RCR_STATUS_POR = 2'h3;
   // restart targets
   localparam logic [15:0] RCR_PC_ZERO = 16'h0000;
   localparam logic [15:0] RCR_PC_VECTOR = 16'h0004;
   // event index = interrupt status bit
   localparam int RCR_NEV = 9;
   localparam int RCR_EV_BROWN = 0;
   localparam int RCR_EV_WDOG = 1;
   localparam int RCR_EV_WINV = 2;
   localparam int RCR_EV_PIN = 3;
   localparam int RCR_EV_INSTR = 4;
   localparam int RCR_EV_STKOVR = 5;
   localparam int RCR_EV_STKUND = 6;
   localparam int RCR_EV_WAKE_WD = 7;
   localparam int RCR_EV_WAKE_IRQ = 8;
   // ctrl register
   localparam int RCR_B_STKEN = 0;
   localparam int RCR_B_GIE = 1;
   localparam logic [1:0] RCR_CTRL_RST = 2'h1;
   // restart kinds
   typedef enum logic [1:0] {RCR_GO_NONE, RCR_GO_ZERO, RCR_GO_NEXT, RCR_GO_VEC} rcr_go_e;
endpackage

// ---- rtl/rcr_sync.sv ----
// rcr_sync: three-flop synchroniser with agreement check, one bit
// assumes an asynchronous input; output changes when stages 2 and 3 agree
`timescale 1ns/1ps
module rcr_sync (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_async,
   output logic o_level,
   output logic o_rise
);
   logic s1;
   logic s2;
   logic s3;
   // s1 feeds only s2
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end
   // one-cycle pulse on a settled rise
   assign o_rise = (s2 == s3) && s3 && !o_level;
endmodule // rcr_sync

// ---- tb/testbench.sv ----
// testbench: self-checking bench for the reset cause recorder, tests as register sequences
// assumes rcr_pkg and rcr_top compiled first; one slave, so hreadyout is the bus hready
`timescale 1ns/1ps
module testbench;
   import rcr_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic pin = 1'b1;
   logic sleeping = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [8:0] ev = 9'h000;
   logic [15:0] pc = 16'h0000;
   logic [31:0] dummy;
   wire [31:0] hrdata;
   wire hready;
   wire hresp;
   wire restart;
   wire irq;
   wire [15:0] rpc;
   int n_fail = 0;
   int total_checks = 0;

   // free-running core clock, 10 ns period
   always #5 i_core_clk = ~i_core_clk;

   rcr_top dut_u (
      .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_brownout(ev[RCR_EV_BROWN]), .i_wdog_timeout(ev[RCR_EV_WDOG]),
      .i_wdog_window_viol(ev[RCR_EV_WINV]), .i_ext_reset_pin(pin),
      .i_reset_instr(ev[RCR_EV_INSTR]), .i_stack_over(ev[RCR_EV_STKOVR]),
      .i_stack_under(ev[RCR_EV_STKUND]), .i_wake_wdog(ev[RCR_EV_WAKE_WD]),
      .i_wake_irq(ev[RCR_EV_WAKE_IRQ]), .i_sleeping(sleeping), .i_pc(pc),
      .o_restart(restart), .o_restart_pc(rpc), .o_irq(irq)
   );

   // four-state compare so an unknown never counts as a match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   `define CHECK(g, e) chk(g, e)

   // single ahb-lite transfer; read data taken at the edge that ends the data phase
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge i_core_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge i_core_clk);
      while (hready !== 1'b1) @(posedge i_core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge i_core_clk);
      while (hready !== 1'b1) @(posedge i_core_clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, dummy);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(a, 1'b0, 32'h0, d);
      `CHECK(d, e);
   endtask

   // flags and status read back together
   task automatic flg(input logic [7:0] f, input logic [7:0] s);
      rdc(RCR_OFF_PWRCTL, {24'h0, f});
      rdc(RCR_OFF_STATUS, {24'h0, s});
   endtask

   // one-cycle event pulse, restart looked at in the cycle after
   task automatic pulse(input int i, input logic r, input logic [15:0] p);
      @(posedge i_core_clk);
      ev[i] <= 1'b1;
      @(posedge i_core_clk);
      ev[i] <= 1'b0;
      #1;
      `CHECK(restart, r);
      if (r) `CHECK(rpc, p);
   endtask

   // pin held low well past the synchroniser depth, then released
   task automatic pinrst();
      @(posedge i_core_clk);
      pin <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      pin <= 1'b1;
      repeat (8) @(posedge i_core_clk);
   endtask

   task automatic give_verdict();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // hang guard; the full sequence needs well under a thousand cycles
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end

   initial begin
      repeat (3) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      flg(8'h3C, 8'h18);
      `CHECK(irq, 1'b0);
      rdc(RCR_OFF_CTRL, 32'h1);
      rdc(RCR_OFF_PC, 32'h0);
      wr(RCR_OFF_PWRCTL, 32'h03);
      flg(8'h3F, 8'h18);
      pulse(RCR_EV_INSTR, 1'b1, 16'h0000);
      flg(8'h3B, 8'h18);
      pulse(RCR_EV_WDOG, 1'b1, 16'h0000);
      flg(8'h2B, 8'h08);
      pulse(RCR_EV_WINV, 1'b1, 16'h0000);
      flg(8'h0B, 8'h18);
      pinrst();
      flg(8'h03, 8'h18);
      `CHECK(rpc, 16'h0000);
      // interrupt status collects every event so far; mask and clear it
      rdc(RCR_OFF_IRQ_ST, 32'h1E);
      `CHECK(irq, 1'b0);
      wr(RCR_OFF_IRQ_MSK, 32'h10);
      #1;
      `CHECK(irq, 1'b1);
      wr(RCR_OFF_IRQ_ST, 32'h1E);
      #1;
      `CHECK(irq, 1'b0);
      rdc(RCR_OFF_IRQ_ST, 32'h0);
      wr(RCR_OFF_IRQ_MSK, 32'h0);
      rdc(8'h40, 32'h0);
      // ones on the stack bits must not set them; zeros elsewhere must not clear
      wr(RCR_OFF_PWRCTL, 32'hFF);
      flg(8'h3F, 8'h18);
      pulse(RCR_EV_STKOVR, 1'b1, 16'h0000);
      pulse(RCR_EV_STKUND, 1'b1, 16'h0000);
      flg(8'hFF, 8'h18);
      wr(RCR_OFF_PWRCTL, 32'h00);
      flg(8'h3F, 8'h18);
      wr(RCR_OFF_CTRL, 32'h0);
      pulse(RCR_EV_STKOVR, 1'b0, 16'h0000);
      flg(8'h3F, 8'h18);
      // sleep-time events
      @(posedge i_core_clk);
      sleeping <= 1'b1;
      pc <= 16'h0123;
      pinrst();
      flg(8'h37, 8'h10);
      `CHECK(rpc, 16'h0000);
      pulse(RCR_EV_WAKE_WD, 1'b1, 16'h0124);
      flg(8'h37, 8'h00);
      pulse(RCR_EV_WAKE_IRQ, 1'b1, 16'h0124);
      flg(8'h37, 8'h10);
      wr(RCR_OFF_CTRL, 32'h3);
      pulse(RCR_EV_WAKE_IRQ, 1'b1, 16'h0004);
      @(posedge i_core_clk);
      sleeping <= 1'b0;
      pulse(RCR_EV_STKOVR, 1'b1, 16'h0000);
      flg(8'hB7, 8'h10);
      pulse(RCR_EV_BROWN, 1'b1, 16'h0000);
      flg(8'h3E, 8'h18);
      give_verdict();
   end
endmodule // testbench
